// File: shared/bwo_pkg.sv
// shared constants and types for the buffered waveform output block
package bwo_pkg;
	localparam int CH_NUM = 4;
	localparam int CH_W = 2;
	localparam int BYTES_MIN = 32;
	localparam int BYTES_MAX = 16384;
	localparam int ADDR_W = 16;
	localparam int DATA_W = 32;
	localparam int SMP_W = 16;
	localparam int TGT_W = 16;
	localparam int UPD_W = TGT_W + SMP_W;
	// ------------------------------------------------------------
	// register addresses; 32-bit registers step by two, 16-bit by one
	// ------------------------------------------------------------
	localparam logic [15:0] A_TARGET = 16'h0fc8;
	localparam logic [15:0] A_BYTES = 16'h0fd2;
	localparam logic [15:0] A_LOOP = 16'h0fdc;
	localparam logic [15:0] A_COMMIT = 16'h0fe6;
	localparam logic [15:0] A_STATUS = 16'h0ff0;
	localparam logic [15:0] A_ENABLE = 16'h0ffa;
	localparam logic [15:0] A_F32 = 16'h1130;
	localparam logic [15:0] A_U16 = 16'h1144;
	localparam logic [15:0] A_SLOT = 16'h12c0;
	// ------------------------------------------------------------
	// target codes
	// ------------------------------------------------------------
	localparam logic [15:0] T_AOUT0 = 16'h03e8;
	localparam logic [15:0] T_AOUT1 = 16'h03ea;
	localparam logic [15:0] T_PF_LVL = 16'h09c4;
	localparam logic [15:0] T_PE_LVL = 16'h09c5;
	localparam logic [15:0] T_PC_LVL = 16'h09c6;
	localparam logic [15:0] T_PM_LVL = 16'h09c7;
	localparam logic [15:0] T_PF_DIR = 16'h0a28;
	localparam logic [15:0] T_PE_DIR = 16'h0a29;
	localparam logic [15:0] T_PC_DIR = 16'h0a2a;
	localparam logic [15:0] T_PM_DIR = 16'h0a2b;
	// ------------------------------------------------------------
	// commit codes, enable codes and reset values
	// ------------------------------------------------------------
	localparam logic [31:0] COMMIT_NOW = 32'h1;
	localparam logic [31:0] COMMIT_WAIT = 32'h2;
	localparam logic [31:0] COMMIT_SYNC = 32'h3;
	localparam logic [31:0] EN_ON = 32'h1;
	localparam logic [31:0] EN_OFF = 32'h0;
	localparam logic [15:0] RST_TARGET = T_AOUT0;
	localparam logic [31:0] RST_BYTES = 32'h20;
	// ------------------------------------------------------------
	// float conversion: codes per volt in q8.8, code offset
	// ------------------------------------------------------------
	localparam logic [15:0] CAL_GAIN = 16'h3333;
	localparam logic [15:0] CAL_OFFSET = 16'h0000;
	localparam logic [7:0] EXP_FIX = 8'h86;
	localparam logic [7:0] EXP_MIN = 8'h6f;
	localparam logic [7:0] EXP_MAX = 8'h8e;
	typedef enum logic [2:0] {
		CH_IDLE = 3'b001,
		CH_PLAY = 3'b010,
		CH_DRY = 3'b100
	} bwo_ch_st_t;
endpackage

// File: shared/bwo_pipe_if.sv
// valid/ready carrier between the playback core and its output buffer
`timescale 1ns/1ps
interface bwo_pipe_if #(parameter int W = 32);
	logic valid;
	logic ready;
	logic [W-1:0] data;
	modport src(output valid, output data, input ready);
	modport snk(input valid, input data, output ready);
endinterface

// File: hw/bwo_f32_code.sv
// float volts to 16-bit output code with calibration gain and offset
`timescale 1ns/1ps
module bwo_f32_code (
	// conversion
	input wire logic [31:0] f32_in,
	output logic [15:0] code_out
);
	import bwo_pkg::*;
	logic [7:0] ex;
	logic [23:0] man;
	logic [39:0] volts;
	logic [55:0] prod;
	logic [56:0] sum;
	always_comb begin
		ex = f32_in[30:23];
		man = {1'b1, f32_in[22:0]};
		volts = '0;
		prod = '0;
		sum = '0;
		if (f32_in[31] || ex < EXP_MIN) begin
			// negative or tiny volts clamp to the bottom code
			code_out = CAL_OFFSET;
		end else if (ex > EXP_MAX) begin
			code_out = 16'hffff;
		end else begin
			if (ex >= EXP_FIX) begin
				volts = 40'(man) << (ex - EXP_FIX);
			end else begin
				volts = 40'(man) >> (EXP_FIX - ex);
			end
			prod = 56'(volts) * 56'(CAL_GAIN);
			sum = 57'(prod >> 24) + 57'(CAL_OFFSET);
			code_out = (sum > 57'hffff) ? 16'hffff : sum[15:0];
		end
	end
endmodule

// File: hw/bwo_skid.sv
// two-entry buffer between scan updates and the target writer
`timescale 1ns/1ps
module bwo_skid #(
	parameter int W = 32
) (
	// clock and reset
	input wire logic ref_clk_in,
	input wire logic rst_n_in,
	// streams
	bwo_pipe_if.snk up,
	bwo_pipe_if.src dn
);
	import bwo_pkg::*;
	logic [W-1:0] slot0, slot1, next_slot0, next_slot1;
	logic [1:0] cnt, next_cnt;
	logic rdy, vld, next_rdy, next_vld, push, pop;
	assign up.ready = rdy;
	assign dn.valid = vld;
	assign dn.data = slot0;
	always_comb begin
		push = up.valid && rdy;
		pop = vld && dn.ready;
		next_slot0 = slot0;
		next_slot1 = slot1;
		next_cnt = cnt;
		if (pop && !push) begin
			next_slot0 = slot1;
			next_cnt = cnt - 2'h1;
		end else if (push && !pop) begin
			if (cnt == 2'h0) begin
				next_slot0 = up.data;
			end else begin
				next_slot1 = up.data;
			end
			next_cnt = cnt + 2'h1;
		end else if (push && pop) begin
			// count is one here: head leaves, new word takes its place
			next_slot0 = up.data;
		end
		next_rdy = next_cnt != 2'h2;
		next_vld = next_cnt != 2'h0;
	end
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			slot0 <= '0;
			slot1 <= '0;
			cnt <= 2'h0;
			rdy <= 1'b0;
			vld <= 1'b0;
		end else begin
			slot0 <= next_slot0;
			slot1 <= next_slot1;
			cnt <= next_cnt;
			rdy <= next_rdy;
			vld <= next_vld;
		end
	end
	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	a_skid_order: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		push && cnt == 2'h0 |=> vld && slot0 == $past(up.data))
		else $error("skid buffer lost word order");
	a_skid_bound: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		cnt != 2'h3 && !(rdy && cnt == 2'h2) && (rdy || cnt == 2'h2 || !$past(rst_n_in)))
		else $error("skid buffer count out of range");
endmodule

// File: hw/bwo_top.sv
// buffered waveform output: registers, channel buffers, scan-driven playback
`timescale 1ns/1ps
module bwo_top #(
	parameter int MAX_BYTES = bwo_pkg::BYTES_MAX
) (
	// clock and reset
	input wire logic ref_clk_in,
	input wire logic rst_n_in,
	// register access port
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	input wire logic [bwo_pkg::ADDR_W-1:0] reg_addr_in,
	input wire logic [bwo_pkg::DATA_W-1:0] reg_wdata_in,
	output logic [bwo_pkg::DATA_W-1:0] reg_rdata_out,
	output logic reg_rvalid_out,
	// scan engine
	input wire logic stream_run_in,
	input wire logic scan_valid_in,
	input wire logic [bwo_pkg::ADDR_W-1:0] scan_entry_in,
	output logic scan_ready_out,
	// target updates
	output logic upd_valid_out,
	input wire logic upd_ready_in,
	output logic [bwo_pkg::TGT_W-1:0] upd_target_out,
	output logic [bwo_pkg::SMP_W-1:0] upd_value_out
);
	import bwo_pkg::*;
	localparam int DEPTH = MAX_BYTES / 2;
	localparam int PW = $clog2(DEPTH);
	localparam int LW = PW + 1;
	localparam int BW = PW + 2;
	// ------------------------------------------------------------
	// address decode helpers
	// ------------------------------------------------------------
	function automatic logic [2:0] dec32(input logic [15:0] a, input logic [15:0] b);
		logic [15:0] d;
		d = a - b;
		return {d[15:3] == 13'h0 && !d[0], d[2:1]};
	endfunction
	function automatic logic [2:0] dec16(input logic [15:0] a, input logic [15:0] b);
		logic [15:0] d;
		d = a - b;
		return {d[15:2] == 14'h0, d[1:0]};
	endfunction
	function automatic logic size_ok(input logic [31:0] v);
		return (v & (v - 32'h1)) == 32'h0 && v >= 32'(BYTES_MIN) && v <= 32'(MAX_BYTES);
	endfunction
	function automatic logic target_ok(input logic [31:0] v);
		case (v)
			32'(T_AOUT0), 32'(T_AOUT1), 32'(T_PF_LVL), 32'(T_PE_LVL), 32'(T_PC_LVL),
			32'(T_PM_LVL), 32'(T_PF_DIR), 32'(T_PE_DIR), 32'(T_PC_DIR),
			32'(T_PM_DIR): return 1'b1;
			default: return 1'b0;
		endcase
	endfunction
	// ------------------------------------------------------------
	// channel state
	// ------------------------------------------------------------
	logic [TGT_W-1:0] target [CH_NUM], next_target [CH_NUM];
	logic [BW-1:0] bytes [CH_NUM], next_bytes [CH_NUM];
	logic [LW-1:0] loop_len [CH_NUM], next_loop_len [CH_NUM];
	bwo_ch_st_t st [CH_NUM], next_st [CH_NUM];
	logic [PW-1:0] wr_ptr [CH_NUM], next_wr_ptr [CH_NUM];
	logic [PW-1:0] rd_ptr [CH_NUM], next_rd_ptr [CH_NUM];
	logic [PW-1:0] end_ptr [CH_NUM], next_end_ptr [CH_NUM];
	logic [LW-1:0] cur_loop [CH_NUM], next_cur_loop [CH_NUM];
	logic [PW-1:0] pend_end [CH_NUM], next_pend_end [CH_NUM];
	logic [LW-1:0] pend_loop [CH_NUM], next_pend_loop [CH_NUM];
	logic pend [CH_NUM], next_pend [CH_NUM];
	logic waiting [CH_NUM], next_waiting [CH_NUM];
	logic [PW-1:0] mask [CH_NUM];
	logic [LW-1:0] free [CH_NUM];
	logic [SMP_W-1:0] mem [CH_NUM][DEPTH];
	logic [2:0] d_tgt, d_byt, d_loop, d_cmt, d_sta, d_ena, d_f32, d_u16, d_scan;
	logic [15:0] f32_code;
	logic sync_all;
	always_comb begin
		d_tgt = dec32(reg_addr_in, A_TARGET);
		d_byt = dec32(reg_addr_in, A_BYTES);
		d_loop = dec32(reg_addr_in, A_LOOP);
		d_cmt = dec32(reg_addr_in, A_COMMIT);
		d_sta = dec32(reg_addr_in, A_STATUS);
		d_ena = dec32(reg_addr_in, A_ENABLE);
		d_f32 = dec32(reg_addr_in, A_F32);
		d_u16 = dec16(reg_addr_in, A_U16);
		d_scan = dec16(scan_entry_in, A_SLOT);
		sync_all = reg_wr_in && d_cmt[2] && reg_wdata_in == COMMIT_SYNC;
		for (int c = 0; c < CH_NUM; c++) begin
			mask[c] = PW'((bytes[c] >> 1) - 1'b1);
			free[c] = LW'(bytes[c] >> 1) - LW'((wr_ptr[c] - rd_ptr[c]) & mask[c]);
		end
	end
	bwo_f32_code u_conv (
		.f32_in(reg_wdata_in),
		.code_out(f32_code)
	);
	// ------------------------------------------------------------
	// scan update path
	// ------------------------------------------------------------
	bwo_pipe_if #(.W(UPD_W)) up_if ();
	bwo_pipe_if #(.W(UPD_W)) dn_if ();
	logic [CH_W-1:0] sc;
	logic hit, emit, at_end;
	logic [PW-1:0] e_sel, p_sel, m_sel;
	logic [LW-1:0] l_sel;
	always_comb begin
		sc = d_scan[1:0];
		m_sel = mask[sc];
		at_end = rd_ptr[sc] == end_ptr[sc];
		// a pending sequence is adopted only when the current one runs out
		e_sel = (at_end && pend[sc]) ? pend_end[sc] : end_ptr[sc];
		l_sel = (at_end && pend[sc]) ? pend_loop[sc] : cur_loop[sc];
		hit = scan_valid_in && stream_run_in && d_scan[2] && st[sc] != CH_IDLE && up_if.ready;
		p_sel = rd_ptr[sc];
		emit = 1'b1;
		if (rd_ptr[sc] == e_sel) begin
			p_sel = (e_sel - l_sel[PW-1:0]) & m_sel;
			emit = l_sel != '0;
		end
	end
	assign up_if.valid = hit && emit;
	assign up_if.data = {target[sc], mem[sc][p_sel]};
	assign dn_if.ready = upd_ready_in;
	// a full buffer holds the scan engine rather than dropping an update
	assign scan_ready_out = up_if.ready;
	assign upd_valid_out = dn_if.valid;
	assign upd_target_out = dn_if.data[UPD_W-1:SMP_W];
	assign upd_value_out = dn_if.data[SMP_W-1:0];
	bwo_skid #(.W(UPD_W)) u_skid (
		.ref_clk_in(ref_clk_in),
		.rst_n_in(rst_n_in),
		.up(up_if),
		.dn(dn_if)
	);
	// ------------------------------------------------------------
	// channel next state
	// ------------------------------------------------------------
	always_comb begin
		for (int c = 0; c < CH_NUM; c++) begin
			next_target[c] = target[c];
			next_bytes[c] = bytes[c];
			next_loop_len[c] = loop_len[c];
			next_st[c] = st[c];
			next_wr_ptr[c] = wr_ptr[c];
			next_rd_ptr[c] = rd_ptr[c];
			next_end_ptr[c] = end_ptr[c];
			next_cur_loop[c] = cur_loop[c];
			next_pend_end[c] = pend_end[c];
			next_pend_loop[c] = pend_loop[c];
			next_pend[c] = pend[c];
			next_waiting[c] = waiting[c];
			if (hit && sc == CH_W'(c)) begin
				if (at_end && pend[c]) begin
					next_end_ptr[c] = pend_end[c];
					next_cur_loop[c] = pend_loop[c];
					next_pend[c] = 1'b0;
				end
				if (emit) begin
					next_rd_ptr[c] = (p_sel + 1'b1) & mask[c];
					next_st[c] = CH_PLAY;
				end else begin
					next_st[c] = CH_DRY;
				end
			end
			// writes land whether or not the stream runs
			if (reg_wr_in) begin
				if (d_tgt[2] && d_tgt[1:0] == CH_W'(c) && target_ok(reg_wdata_in)) begin
					next_target[c] = reg_wdata_in[TGT_W-1:0];
				end
				if (d_byt[2] && d_byt[1:0] == CH_W'(c) && size_ok(reg_wdata_in)) begin
					next_bytes[c] = BW'(reg_wdata_in);
					next_wr_ptr[c] = '0;
					next_rd_ptr[c] = '0;
					next_end_ptr[c] = '0;
					next_cur_loop[c] = '0;
					next_pend[c] = 1'b0;
					next_waiting[c] = 1'b0;
				end
				if (d_loop[2] && d_loop[1:0] == CH_W'(c)) begin
					next_loop_len[c] = LW'(reg_wdata_in);
				end
				if (d_ena[2] && d_ena[1:0] == CH_W'(c)) begin
					if (reg_wdata_in == EN_ON && st[c] == CH_IDLE) begin
						next_st[c] = CH_PLAY;
					end else if (reg_wdata_in == EN_OFF) begin
						next_st[c] = CH_IDLE;
					end
				end
				if (d_cmt[2] && d_cmt[1:0] == CH_W'(c)) begin
					if (reg_wdata_in == COMMIT_NOW) begin
						next_pend[c] = 1'b1;
						next_pend_end[c] = wr_ptr[c];
						next_pend_loop[c] = loop_len[c];
					end else if (reg_wdata_in == COMMIT_WAIT) begin
						next_waiting[c] = 1'b1;
					end
				end
				// the write pointer runs free; an overrun simply overwrites
				if ((d_u16[2] && d_u16[1:0] == CH_W'(c)) || (d_f32[2] && d_f32[1:0] == CH_W'(c))) begin
					next_wr_ptr[c] = (wr_ptr[c] + 1'b1) & mask[c];
				end
			end
			if (sync_all && (waiting[c] || d_cmt[1:0] == CH_W'(c))) begin
				next_pend[c] = 1'b1;
				next_pend_end[c] = wr_ptr[c];
				next_pend_loop[c] = loop_len[c];
				next_waiting[c] = 1'b0;
			end
		end
	end
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			for (int c = 0; c < CH_NUM; c++) begin
				target[c] <= RST_TARGET;
				bytes[c] <= BW'(RST_BYTES);
				loop_len[c] <= '0;
				st[c] <= CH_IDLE;
				wr_ptr[c] <= '0;
				rd_ptr[c] <= '0;
				end_ptr[c] <= '0;
				cur_loop[c] <= '0;
				pend_end[c] <= '0;
				pend_loop[c] <= '0;
				pend[c] <= 1'b0;
				waiting[c] <= 1'b0;
			end
		end else begin
			target <= next_target;
			bytes <= next_bytes;
			loop_len <= next_loop_len;
			st <= next_st;
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
			end_ptr <= next_end_ptr;
			cur_loop <= next_cur_loop;
			pend_end <= next_pend_end;
			pend_loop <= next_pend_loop;
			pend <= next_pend;
			waiting <= next_waiting;
		end
	end
	// ------------------------------------------------------------
	// sample storage, no reset: contents are defined by host writes
	// ------------------------------------------------------------
	logic mem_we;
	logic [CH_W-1:0] mem_ch;
	logic [SMP_W-1:0] mem_val;
	always_comb begin
		mem_we = reg_wr_in && (d_u16[2] || d_f32[2]);
		mem_ch = d_u16[2] ? d_u16[1:0] : d_f32[1:0];
		// word port keeps the low half; float port goes through calibration
		mem_val = d_u16[2] ? reg_wdata_in[SMP_W-1:0] : f32_code;
	end
	always_ff @(posedge ref_clk_in) begin
		if (mem_we) begin
			mem[mem_ch][wr_ptr[mem_ch]] <= mem_val;
		end
	end
	// ------------------------------------------------------------
	// register reads, one cycle after the strobe
	// ------------------------------------------------------------
	logic [DATA_W-1:0] next_rdata;
	always_comb begin
		next_rdata = '0;
		if (reg_rd_in) begin
			if (d_tgt[2]) begin
				next_rdata = 32'(target[d_tgt[1:0]]);
			end else if (d_byt[2]) begin
				next_rdata = 32'(bytes[d_byt[1:0]]);
			end else if (d_loop[2]) begin
				next_rdata = 32'(loop_len[d_loop[1:0]]);
			end else if (d_ena[2]) begin
				next_rdata = 32'(st[d_ena[1:0]] != CH_IDLE);
			end else if (d_sta[2]) begin
				next_rdata = 32'(free[d_sta[1:0]]);
			end
		end
	end
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			reg_rdata_out <= '0;
			reg_rvalid_out <= 1'b0;
		end else begin
			reg_rdata_out <= next_rdata;
			reg_rvalid_out <= reg_rd_in;
		end
	end
	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (!rst_n_in);
	a_push_running: assert property (up_if.valid |-> stream_run_in && scan_valid_in && d_scan[2])
		else $error("update without running scan");
	a_disable_stops: assert property (
		reg_wr_in && d_ena == 3'b100 && reg_wdata_in == EN_OFF |=> st[0] == CH_IDLE && !(up_if.valid && sc == 2'h0))
		else $error("disabled channel still updates");
	a_status_value: assert property (
		reg_rd_in && d_sta == 3'b100 |=> reg_rvalid_out && reg_rdata_out == 32'($past(free[0])))
		else $error("status read wrong");
	a_word_append: assert property (
		reg_wr_in && d_u16 == 3'b100 |=> wr_ptr[0] == (($past(wr_ptr[0]) + 1'b1) & $past(mask[0])))
		else $error("word write did not advance pointer");
	a_size_legal: assert property (
		(bytes[0] & (bytes[0] - 1'b1)) == '0 && bytes[0] >= BW'(BYTES_MIN))
		else $error("buffer size illegal");
	a_commit_now: assert property (
		reg_wr_in && d_cmt == 3'b100 && reg_wdata_in == COMMIT_NOW |=> pend[0] && pend_end[0] == $past(wr_ptr[0]))
		else $error("commit now not latched");
	a_sync_release: assert property (sync_all |=> !waiting[0] && !waiting[1] && !waiting[2] && !waiting[3])
		else $error("waiting channel not released by sync");
	a_loop_replay: assert property (
		hit && sc == 2'h0 && at_end && !pend[0] && cur_loop[0] != '0
		|=> rd_ptr[0] == (($past(end_ptr[0]) - $past(cur_loop[0][PW-1:0]) + 1'b1) & $past(mask[0])))
		else $error("loop did not replay tail");
	a_dry_hold: assert property (hit && !emit |-> !up_if.valid ##1 st[$past(sc)] == CH_DRY)
		else $error("empty channel emitted");
	c_loop_wrap: cover property (hit && emit && rd_ptr[sc] == e_sel);
	c_sync_all: cover property (sync_all && (waiting[0] || waiting[1] || waiting[2] || waiting[3]));
	c_stall: cover property (scan_valid_in && !up_if.ready);
	c_dry: cover property (hit && !emit);
endmodule

// File: bench/bwo_host.sv
// host register client and target-update consumer for the waveform block
`timescale 1ns/1ps
module bwo_host (
	// clock
	input wire logic ref_clk_in,
	// register access
	output logic reg_wr_out,
	output logic reg_rd_out,
	output logic [15:0] reg_addr_out,
	output logic [31:0] reg_wdata_out,
	input wire logic [31:0] reg_rdata_in,
	input wire logic reg_rvalid_in,
	// target updates
	input wire logic upd_valid_in,
	output logic upd_ready_out,
	input wire logic [15:0] upd_target_in,
	input wire logic [15:0] upd_value_in
);
	logic stall;
	logic [31:0] got_q[$];
	initial begin
		stall = 1'b0;
		reg_wr_out = 1'b0;
		reg_rd_out = 1'b0;
		reg_addr_out = 16'hffff;
		reg_wdata_out = 32'h0;
		upd_ready_out = 1'b0;
	end
	// ------------------------------------------------------------
	// consumer: stalls on request, keeps every accepted update
	// ------------------------------------------------------------
	always @(negedge ref_clk_in) begin
		upd_ready_out <= !stall;
	end
	always @(posedge ref_clk_in) begin
		if (upd_valid_in === 1'b1 && upd_ready_out === 1'b1) begin
			got_q.push_back({upd_target_in, upd_value_in});
		end
	end
	// ------------------------------------------------------------
	// register cycles; released lines show inverted values
	// ------------------------------------------------------------
	task automatic wr(input logic [15:0] a, input logic [31:0] d);
		@(negedge ref_clk_in);
		reg_wr_out = 1'b1;
		reg_addr_out = a;
		reg_wdata_out = d;
		@(negedge ref_clk_in);
		reg_wr_out = 1'b0;
		reg_addr_out = ~a;
		reg_wdata_out = ~d;
	endtask
	task automatic rd(input logic [15:0] a, output logic [31:0] d);
		@(negedge ref_clk_in);
		reg_rd_out = 1'b1;
		reg_addr_out = a;
		@(negedge ref_clk_in);
		reg_rd_out = 1'b0;
		reg_addr_out = ~a;
		d = (reg_rvalid_in === 1'b1) ? reg_rdata_in : 32'hxxxxxxxx;
	endtask
endmodule

// File: bench/testbench.sv
// self-checking bench for the buffered waveform output block
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin error_cnt++; \
	$display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end
module testbench;
	import bwo_pkg::*;
	logic ref_clk_in, rst_n_in, reg_wr_in, reg_rd_in, reg_rvalid_out, stream_run_in;
	logic scan_valid_in, scan_ready_out, upd_valid_out, upd_ready_in;
	logic [15:0] reg_addr_in, scan_entry_in, upd_target_out, upd_value_out;
	logic [31:0] reg_wdata_in, reg_rdata_out, d;
	int error_cnt = 0;
	int checked = 0;
	// small buffers keep memory short: 128 entries at most
	bwo_top #(.MAX_BYTES(256)) DUT (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
		.reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_addr_in(reg_addr_in),
		.reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
		.reg_rvalid_out(reg_rvalid_out), .stream_run_in(stream_run_in),
		.scan_valid_in(scan_valid_in), .scan_entry_in(scan_entry_in),
		.scan_ready_out(scan_ready_out), .upd_valid_out(upd_valid_out),
		.upd_ready_in(upd_ready_in), .upd_target_out(upd_target_out),
		.upd_value_out(upd_value_out));
	bwo_host host (.ref_clk_in(ref_clk_in), .reg_wr_out(reg_wr_in), .reg_rd_out(reg_rd_in),
		.reg_addr_out(reg_addr_in), .reg_wdata_out(reg_wdata_in),
		.reg_rdata_in(reg_rdata_out), .reg_rvalid_in(reg_rvalid_out),
		.upd_valid_in(upd_valid_out), .upd_ready_out(upd_ready_in),
		.upd_target_in(upd_target_out), .upd_value_in(upd_value_out));
	always #2.5 ref_clk_in = ~ref_clk_in;
	// ------------------------------------------------------------
	// shared helpers
	// ------------------------------------------------------------
	task automatic close_out;
		$display("checks %0d errors %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task automatic scan(input logic [15:0] e);
		int i;
		@(negedge ref_clk_in);
		scan_valid_in = 1'b1;
		scan_entry_in = e;
		for (i = 0; i < 200 && scan_ready_out !== 1'b1; i++) begin
			@(negedge ref_clk_in);
		end
		if (i == 200) begin
			error_cnt++;
			close_out();
		end
		@(negedge ref_clk_in);
		scan_valid_in = 1'b0;
		scan_entry_in = ~e;
	endtask
	task automatic expect_upd(input logic [15:0] t, input logic [15:0] v);
		int i;
		logic [31:0] g;
		for (i = 0; i < 200 && host.got_q.size() == 0; i++) begin
			@(negedge ref_clk_in);
		end
		if (i == 200) begin
			error_cnt++;
			close_out();
		end
		g = host.got_q.pop_front();
		`CHK(g, {t, v})
	endtask
	task automatic expect_none;
		repeat (6) @(negedge ref_clk_in);
		`CHK(host.got_q.size(), 0)
	endtask
	task automatic rchk(input logic [15:0] a, input logic [31:0] e);
		host.rd(a, d);
		`CHK(d, e)
	endtask
	task automatic setup(input int ch, input logic [15:0] t, input logic [31:0] b);
		host.wr(A_TARGET + 16'(2 * ch), {16'h0, t});
		host.wr(A_BYTES + 16'(2 * ch), b);
		host.wr(A_ENABLE + 16'(2 * ch), EN_ON);
	endtask
	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_reset_regs;
		rchk(A_TARGET, {16'h0, T_AOUT0});
		rchk(A_BYTES, RST_BYTES);
		rchk(A_LOOP, 32'h0);
		rchk(A_ENABLE, EN_OFF);
		rchk(A_STATUS, 32'h10);
		rchk(A_COMMIT, 32'h0);
		rchk(16'h0100, 32'h0);
	endtask
	task automatic t_refuse;
		host.wr(A_BYTES + 16'h2, 32'h30);
		host.wr(A_BYTES + 16'h2, 32'h200);
		host.wr(A_TARGET + 16'h2, 32'h3e9);
		host.wr(A_ENABLE + 16'h2, 32'h2);
		rchk(A_BYTES + 16'h2, 32'h20);
		rchk(A_TARGET + 16'h2, {16'h0, T_AOUT0});
		rchk(A_ENABLE + 16'h2, EN_OFF);
		host.wr(A_BYTES + 16'h2, 32'h100);
		rchk(A_BYTES + 16'h2, 32'h100);
		rchk(A_STATUS + 16'h2, 32'h80);
	endtask
	task automatic t_targets;
		logic [15:0] tl[10] = '{T_AOUT0, T_AOUT1, T_PF_LVL, T_PE_LVL, T_PC_LVL, T_PM_LVL,
			T_PF_DIR, T_PE_DIR, T_PC_DIR, T_PM_DIR};
		foreach (tl[i]) begin
			host.wr(A_TARGET + 16'h2, {16'h0, tl[i]});
			rchk(A_TARGET + 16'h2, {16'h0, tl[i]});
		end
	endtask
	task automatic t_loop;
		setup(0, T_AOUT1, 32'h40);
		host.wr(A_U16, 32'h000a0011);
		host.wr(A_U16, 32'h00000022);
		host.wr(A_U16, 32'hffff0033);
		host.wr(A_U16, 32'h00000044);
		rchk(A_STATUS, 32'h1c);
		host.wr(A_LOOP, 32'h4);
		host.wr(A_COMMIT, COMMIT_NOW);
		stream_run_in = 1'b1;
		repeat (6) scan(A_SLOT);
		expect_upd(T_AOUT1, 16'h11);
		expect_upd(T_AOUT1, 16'h22);
		expect_upd(T_AOUT1, 16'h33);
		expect_upd(T_AOUT1, 16'h44);
		expect_upd(T_AOUT1, 16'h11);
		expect_upd(T_AOUT1, 16'h22);
	endtask
	task automatic t_gate;
		stream_run_in = 1'b0;
		scan(A_SLOT);
		expect_none();
		stream_run_in = 1'b1;
		host.wr(A_ENABLE, EN_OFF);
		scan(A_SLOT);
		scan(16'h0000);
		expect_none();
		host.wr(A_ENABLE, EN_ON);
	endtask
	task automatic t_order_stall;
		setup(1, T_PF_LVL, 32'h20);
		host.wr(A_U16 + 16'h1, 32'h1);
		host.wr(A_U16 + 16'h1, 32'h0);
		host.wr(A_LOOP + 16'h2, 32'h2);
		host.wr(A_COMMIT + 16'h2, COMMIT_NOW);
		host.stall = 1'b1;
		fork
			begin
				repeat (12) @(negedge ref_clk_in);
				host.stall = 1'b0;
			end
		join_none
		scan(A_SLOT + 16'h1);
		scan(A_SLOT);
		scan(A_SLOT + 16'h1);
		expect_upd(T_PF_LVL, 16'h1);
		expect_upd(T_AOUT1, 16'h33);
		expect_upd(T_PF_LVL, 16'h0);
	endtask
	task automatic t_sync;
		setup(2, T_AOUT1, 32'h20);
		host.wr(A_U16 + 16'h2, 32'h0aaa);
		host.wr(A_LOOP + 16'h4, 32'h1);
		host.wr(A_COMMIT + 16'h4, COMMIT_WAIT);
		scan(A_SLOT + 16'h2);
		expect_none();
		setup(3, T_AOUT0, 32'h20);
		host.wr(A_F32 + 16'h6, 32'h3f800000);
		host.wr(A_F32 + 16'h6, 32'h40000000);
		host.wr(A_LOOP + 16'h6, 32'h2);
		host.wr(A_COMMIT + 16'h6, COMMIT_SYNC);
		scan(A_SLOT + 16'h3);
		scan(A_SLOT + 16'h2);
		scan(A_SLOT + 16'h3);
		expect_upd(T_AOUT0, 16'h0033);
		expect_upd(T_AOUT1, 16'h0aaa);
		expect_upd(T_AOUT0, 16'h0066);
	endtask
	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		ref_clk_in = 1'b0;
		rst_n_in = 1'b0;
		stream_run_in = 1'b0;
		scan_valid_in = 1'b0;
		scan_entry_in = 16'h0;
		repeat (5) @(posedge ref_clk_in);
		@(negedge ref_clk_in);
		rst_n_in = 1'b1;
		t_reset_regs();
		t_refuse();
		t_loop();
		t_targets();
		t_gate();
		t_order_stall();
		t_sync();
		close_out();
	end
endmodule
